// ### logic/i2c_slave_pkg.sv
// Constants, types and helpers shared by the I2C register slave and its write FIFO
package i2c_slave_pkg;
  localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h2b;  // Address used when none is programmed
  localparam logic [7:0] FIRST_RW_REG       = 8'h09;  // Lowest host-writable register
  localparam logic [7:0] REG_ADDR_RESET     = 8'h00;  // Register pointer after reset
  localparam logic [3:0] BYTE_BITS          = 4'h8;   // Bits in one bus byte
  localparam int         FIFO_DEPTH         = 16;     // Pending writes held until a phase
  localparam int         SYS_CLK_MHZ        = 125;    // Sampling clock rate
  localparam int         FAST_SCL_HIGH_NS   = 600;    // Shortest clock high time at 400 kb/s
  localparam int         FAST_SCL_HIGH_CYC  = (FAST_SCL_HIGH_NS * SYS_CLK_MHZ) / 1000;

  // One pending register write
  typedef struct packed {
    logic [7:0] addr;  // Target register
    logic [7:0] data;  // Value to apply
  } reg_write_s;

  // Link states, Gray coded along idle, addr, ack, wdata
  typedef enum logic [2:0] {
    st_idle   = 3'h0,
    st_addr   = 3'h1,
    st_ack    = 3'h3,
    st_wdata  = 3'h2,
    st_rdata  = 3'h6,
    st_mack   = 3'h7,
    st_ignore = 3'h5
  } link_state_e;

  // Status registers sit below the first writable one
  function automatic logic is_writable(input logic [7:0] addr);
    return addr >= FIRST_RW_REG;
  endfunction
endpackage

// ### logic/write_fifo.sv
// Write FIFO with a registered output stage
`timescale 1ns/1ps
module write_fifo
  import i2c_slave_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = FIFO_DEPTH,
  localparam int AW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 1)
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [CW-1:0]    level
);
  logic [WIDTH-1:0] mem [DEPTH];  // Storage array
  logic [AW-1:0]    wr_ptr;       // Next slot to fill
  logic [AW-1:0]    rd_ptr;       // Next slot to drain
  logic [CW-1:0]    used;         // Words in the array, output stage excluded
  logic             push;
  logic             load;

  // Wraps a pointer; depth need not be a power of two
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign push     = in_valid && in_ready;
  assign load     = (used != '0) && (!out_valid || out_ready);
  assign in_ready = (CW'(used + CW'(out_valid)) != CW'(DEPTH));  // Output stage counts toward the depth
  assign level    = CW'(used + CW'(out_valid));

  // Array write, no reset needed on data
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      used   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (load) begin
        rd_ptr <= bump(rd_ptr);
      end
      used <= CW'(used + CW'(push) - CW'(load));
    end
  end

  // Output stage keeps read data in a register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// ### logic/i2c_reg_slave.sv
// I2C slave that gives a bus master access to the internal register space
// How it works
// - Oversampled bus works at 100 and 400 kb/s
// - Slave only, 7-bit address default 0x2b
// - Programmed nonvolatile address replaces the default
// - Writes queue until next processing phase start
// - Register pointer advances per further data byte
// - Write: address with direction zero is acknowledged
// - Register address acknowledged; data bytes acked unless the write FIFO is full and the target register is writable
// - Read address acked, then current register driven
// - Master ack fetches next; nack ends read
// - Status registers cannot be written
// - Control registers are readable and writable
`timescale 1ns/1ps
module i2c_reg_slave
  import i2c_slave_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       nvm_addr_valid,
  input  wire logic [6:0] nvm_addr,
  input  wire logic       phase_start,
  output logic            wr_valid,
  output reg_write_s      wr_entry,
  input  wire logic       wr_ready,
  output logic            rd_req,
  output logic      [7:0] rd_addr,
  input  wire logic       rd_ack,
  input  wire logic [7:0] rd_data
);
  localparam int CW = $clog2(DEPTH + 1);

  logic        scl_meta, scl_s, scl_d;  // Clock synchroniser and history
  logic        sda_meta, sda_s, sda_d;  // Data synchroniser and history
  link_state_e state;                   // Link position
  logic [3:0]  bit_cnt;                 // Bits moved in the current byte
  logic [7:0]  shreg;                   // Received byte
  logic [7:0]  tx;                      // Byte being sent
  logic [7:0]  reg_addr;                // Register pointer
  logic        first_byte;              // Next written byte is the pointer
  logic        read_dir;                // Direction bit of the last hit
  logic        master_ack;              // Master acknowledged the last read byte
  logic [6:0]  own_addr;                // Active slave address
  logic        addr_loaded;             // Address chosen after reset
  logic        push_valid;              // Write handed to the FIFO
  reg_write_s  push_data;
  logic [CW-1:0] apply_left;            // Writes still owed to this phase
  logic        fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [15:0] fifo_out_data;
  logic [CW-1:0] fifo_level;

  logic scl_rise, scl_fall, start_cond, stop_cond, byte_full, addr_hit;
  logic addr_done, wbyte_done, wr_accept, mack_rise_ack, drive_bit, fifo_pop;

  assign scl_rise      = scl_s && !scl_d;
  assign scl_fall      = !scl_s && scl_d;
  assign start_cond    = scl_s && scl_d && sda_d && !sda_s;
  assign stop_cond     = scl_s && scl_d && !sda_d && sda_s;
  assign byte_full     = (bit_cnt == BYTE_BITS);
  assign addr_hit      = (shreg[7:1] == own_addr);
  assign addr_done     = (state == st_addr) && scl_fall && byte_full;
  assign wbyte_done    = (state == st_wdata) && scl_fall && byte_full;
  // Writes to status registers are acked but dropped, so only a full FIFO refuses
  assign wr_accept     = first_byte || !is_writable(reg_addr) || fifo_in_ready;
  assign mack_rise_ack = (state == st_mack) && scl_rise && !sda_s;
  assign drive_bit     = scl_fall && (((state == st_ack) && read_dir) ||
                                      ((state == st_rdata) && !byte_full) ||
                                      ((state == st_mack) && master_ack));
  assign fifo_pop       = fifo_out_valid && fifo_out_ready;
  assign fifo_out_ready = (apply_left != '0) && (!wr_valid || wr_ready);

  // Pins pass two flops; bit periods span hundreds of sys_clk cycles
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      {scl_meta, scl_s, scl_d} <= 3'h7;
      {sda_meta, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_meta, scl_s, scl_d} <= {scl_in, scl_meta, scl_s};
      {sda_meta, sda_s, sda_d} <= {sda_in, sda_meta, sda_s};
    end
  end

  // Address picked once after reset release, like a strap
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      own_addr    <= DEFAULT_SLAVE_ADDR;
      addr_loaded <= 1'b0;
    end else if (!addr_loaded) begin
      addr_loaded <= 1'b1;
      own_addr    <= nvm_addr_valid ? nvm_addr : DEFAULT_SLAVE_ADDR;
    end
  end

  // Receive shifter samples on clock rise
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      shreg <= '0;
    end else if (((state == st_addr) || (state == st_wdata)) && scl_rise) begin
      shreg <= {shreg[6:0], sda_s};
    end
  end

  // Link state and data line drive; start and stop override everything
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= st_idle;
      bit_cnt    <= '0;
      sda_oe     <= 1'b0;
      first_byte <= 1'b1;
      read_dir   <= 1'b0;
      master_ack <= 1'b0;
    end else if (start_cond) begin
      state      <= st_addr;
      bit_cnt    <= '0;
      sda_oe     <= 1'b0;
      first_byte <= 1'b1;
    end else if (stop_cond) begin
      state  <= st_idle;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        st_addr: begin
          if (scl_rise) begin
            bit_cnt <= 4'(bit_cnt + 1'b1);
          end
          if (addr_done && addr_hit) begin
            state    <= st_ack;
            sda_oe   <= 1'b1;
            read_dir <= shreg[0];
          end else if (addr_done) begin
            state <= st_ignore;
          end
        end
        st_wdata: begin
          if (scl_rise) begin
            bit_cnt <= 4'(bit_cnt + 1'b1);
          end
          if (wbyte_done && wr_accept) begin
            state      <= st_ack;
            sda_oe     <= 1'b1;
            first_byte <= 1'b0;
          end else if (wbyte_done) begin
            state <= st_ignore;  // Full FIFO: nack, then ignore the rest of the transfer
          end
        end
        st_ack: begin
          if (scl_fall && read_dir) begin
            state   <= st_rdata;
            sda_oe  <= !tx[7];
            bit_cnt <= 4'h1;
          end else if (scl_fall) begin
            state   <= st_wdata;
            sda_oe  <= 1'b0;
            bit_cnt <= '0;
          end
        end
        st_rdata: begin
          if (scl_fall && byte_full) begin
            state  <= st_mack;  // Hand the line to the master
            sda_oe <= 1'b0;
          end else if (scl_fall) begin
            sda_oe  <= !tx[7];
            bit_cnt <= 4'(bit_cnt + 1'b1);
          end
        end
        st_mack: begin
          if (scl_rise) begin
            master_ack <= !sda_s;
          end
          if (scl_fall && master_ack) begin
            state   <= st_rdata;
            sda_oe  <= !tx[7];
            bit_cnt <= 4'h1;
          end else if (scl_fall) begin
            state <= st_ignore;
          end
        end
        st_idle, st_ignore: begin
          sda_oe <= 1'b0;  // Wait for the next start
        end
        default: begin
          state  <= st_idle;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain: only ever pulls low
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Register pointer; after a read it rests on the last byte sent
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_addr <= REG_ADDR_RESET;
    end else if (wbyte_done && wr_accept && first_byte) begin
      reg_addr <= shreg;
    end else if ((wbyte_done && wr_accept) || mack_rise_ack) begin
      reg_addr <= 8'(reg_addr + 1'b1);
    end
  end

  // Fetch requests; responder must answer well inside one clock half period
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_req  <= 1'b0;
      rd_addr <= '0;
    end else begin
      rd_req <= (addr_done && addr_hit && shreg[0]) || mack_rise_ack;
      if (addr_done && addr_hit && shreg[0]) begin
        rd_addr <= reg_addr;
      end else if (mack_rise_ack) begin
        rd_addr <= 8'(reg_addr + 1'b1);
      end
    end
  end

  // Transmit byte loaded by the responder, shifted per driven bit
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx <= '0;
    end else if (rd_ack) begin
      tx <= rd_data;
    end else if (drive_bit) begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  // Queue accepted writes to writable registers only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      push_valid <= 1'b0;
      push_data  <= '0;
    end else begin
      push_valid <= wbyte_done && wr_accept && !first_byte && is_writable(reg_addr);
      push_data  <= '{addr: reg_addr, data: shreg};
    end
  end

  write_fifo #(.WIDTH($bits(reg_write_s)), .DEPTH(DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // Phase start releases only what was queued before it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      apply_left <= '0;
    end else if (phase_start) begin
      apply_left <= CW'(fifo_level - CW'(fifo_pop));
    end else if (fifo_pop) begin
      apply_left <= CW'(apply_left - 1'b1);
    end
  end

  // Output stage toward the register space
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_valid <= 1'b0;
      wr_entry <= '0;
    end else if (fifo_pop) begin
      wr_valid <= 1'b1;
      wr_entry <= reg_write_s'(fifo_out_data);
    end else if (wr_ready) begin
      wr_valid <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence addr_matched;
    addr_done && addr_hit;
  endsequence
  sequence master_nack;
    (state == st_mack) && scl_fall && !master_ack;
  endsequence

  addr_ack_a: assert property (addr_matched |=> (state == st_ack) && sda_oe)
    else $error("own address not acknowledged");
  foreign_addr_a: assert property (addr_done && !addr_hit |=> (state == st_ignore) && !sda_oe)
    else $error("foreign address acknowledged");
  own_addr_a: assert property ($rose(addr_loaded) |->
      own_addr == ($past(nvm_addr_valid) ? $past(nvm_addr) : DEFAULT_SLAVE_ADDR))
    else $error("slave address choice wrong");
  data_ack_a: assert property (wbyte_done && wr_accept |=> sda_oe ##1 sda_oe)
    else $error("written byte not acknowledged");
  ptr_step_a: assert property (wbyte_done && wr_accept && !first_byte |=>
      reg_addr == 8'($past(reg_addr) + 1'b1))
    else $error("register pointer did not advance");
  status_ro_a: assert property (push_valid |-> is_writable(push_data.addr))
    else $error("status register write queued");
  phase_hold_a: assert property (fifo_pop |-> apply_left != '0 || $past(phase_start))
    else $error("write applied outside a phase");
  read_fetch_a: assert property (addr_matched and (shreg[0] == 1'b1) |=>
      rd_req && (rd_addr == $past(reg_addr)))
    else $error("read fetch missing");
  next_fetch_a: assert property (mack_rise_ack |=> rd_req && (rd_addr == reg_addr))
    else $error("next byte not fetched");
  nack_end_a: assert property (master_nack |=> (state == st_ignore) && !sda_oe)
    else $error("read did not end on nack");
endmodule

// ### testbench/i2c_master_model.sv
// Bus master model that drives the link clock and the data line
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  // Bus idle, both lines released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Wait whole system cycles
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One bit: data moves mid-low, is sampled late in the high phase
  task automatic bit_io(input logic b, output logic s);
    scl <= 1'b0;
    tick(2);
    sda_drv <= b;
    tick(2);
    scl <= 1'b1;
    tick(3);
    s = sda;
    tick(1);
  endtask

  // Start, or repeated start while the clock runs
  task automatic start_cond(input logic rep);
    if (rep) begin
      scl <= 1'b0;
      tick(2);
      sda_drv <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
    end
    sda_drv <= 1'b0;
    tick(4);
  endtask

  // Stop: data rises while the clock is high
  task automatic stop_cond();
    scl <= 1'b0;
    tick(2);
    sda_drv <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
  endtask

  // Byte out, MSB first; a low ninth bit is the ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = (s === 1'b0);
  endtask

  // Byte in; ack asks for more, nack ends the read
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(nack, s);
  endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the register slave
`timescale 1ns/1ps
module testbench;
  import i2c_slave_pkg::*;
  logic        sys_clk;         // System clock
  logic        reset_n;         // Async reset
  logic        scl;             // Link clock
  logic        sda_drv;         // Master data drive
  wire         sda;             // Resolved data wire
  logic        sda_out;         // Slave data value
  logic        sda_oe;          // Slave pulls low
  logic        nvm_addr_valid;  // Programmed address flag
  logic [6:0]  nvm_addr;        // Programmed address
  logic        phase_start;     // Phase pulse
  logic        wr_valid;        // Write offered
  reg_write_s  wr_entry;        // Write contents
  logic        wr_ready;        // Consumer ready
  logic        rd_req;          // Fetch request
  logic [7:0]  rd_addr;         // Fetch address
  logic        rd_ack;          // Fetch answer
  logic [7:0]  rd_data;         // Fetched value
  logic [7:0]  regs [256];      // Register space model
  logic [15:0] exp_q [$];       // Writes awaiting a phase
  logic [6:0]  own;             // Address the slave answers
  logic        phase_seen;      // A phase has begun
  integer      seed = 55298;    // Random seed
  int          n_errors = 0;    // Mismatches
  int          compares = 0;    // Comparisons

  // Pull-up wire, open drain on both sides
  assign sda = sda_drv & ~(sda_oe & ~sda_out);

  // System clock, 8 ns
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  i2c_reg_slave #(.DEPTH(FIFO_DEPTH)) DUT (
    .sys_clk        (sys_clk),
    .reset_n        (reset_n),
    .scl_in         (scl),
    .sda_in         (sda),
    .sda_out        (sda_out),
    .sda_oe         (sda_oe),
    .nvm_addr_valid (nvm_addr_valid),
    .nvm_addr       (nvm_addr),
    .phase_start    (phase_start),
    .wr_valid       (wr_valid),
    .wr_entry       (wr_entry),
    .wr_ready       (wr_ready),
    .rd_req         (rd_req),
    .rd_addr        (rd_addr),
    .rd_ack         (rd_ack),
    .rd_data        (rd_data)
  );

  i2c_master_model m (
    .sys_clk (sys_clk),
    .sda     (sda),
    .scl     (scl),
    .sda_drv (sda_drv)
  );

  // Compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Responder answers next cycle; noise when idle so stale data shows
  always @(posedge sys_clk) begin
    rd_ack <= rd_req;
    rd_data <= rd_req ? regs[rd_addr] : 8'($random(seed));
  end

  // Consumer stalls at random, checks bus order
  always @(posedge sys_clk) begin
    wr_ready <= 1'($random(seed));
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      chk("write before phase", 16'h1, 16'(phase_seen));
      chk("write entry", exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx, wr_entry);
    end
  end

  // Addressed write; only writable registers reach the queue
  task automatic bus_write(input logic [6:0] dev, input logic [7:0] ptr, input int n, input int n_ok,
                           input logic hit);
    logic       a;
    logic [7:0] d;
    m.start_cond(1'b0);
    m.send_byte({dev, 1'b0}, a);
    chk("address ack", 16'(hit), 16'(a));
    m.send_byte(ptr, a);
    chk("pointer ack", 16'(hit), 16'(a));
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      m.send_byte(d, a);
      chk("data ack", 16'(hit && i < n_ok), 16'(a));
      if (hit && i < n_ok && ptr >= FIRST_RW_REG) begin
        exp_q.push_back({ptr, d});
      end
      ptr++;
    end
    m.stop_cond();
  endtask

  // Pointer write, repeated start, sequential read
  task automatic bus_read(input logic [7:0] ptr, input int n);
    logic       a;
    logic [7:0] d;
    m.start_cond(1'b0);
    m.send_byte({own, 1'b0}, a);
    chk("address ack", 16'h1, 16'(a));
    m.send_byte(ptr, a);
    chk("pointer ack", 16'h1, 16'(a));
    m.start_cond(1'b1);
    m.send_byte({own, 1'b1}, a);
    chk("read address ack", 16'h1, 16'(a));
    for (int i = 0; i < n; i++) begin
      m.recv_byte(i == n - 1, d);
      chk("read data", 16'(regs[ptr]), 16'(d));
      ptr++;
    end
    m.stop_cond();
  endtask

  // Pulse a phase, wait for the queue to drain
  task automatic apply_phase();
    phase_start <= 1'b1;
    phase_seen = 1'b1;
    @(posedge sys_clk);
    phase_start <= 1'b0;
    for (int i = 0; i < 400 && exp_q.size() > 0; i++) begin
      @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
    chk("writes left", 16'h0, 16'(exp_q.size()));
    chk("extra write", 16'h0, 16'(wr_valid));
    phase_seen = 1'b0;
  endtask

  // Reset with an optional programmed address
  task automatic do_reset(input logic nv, input logic [6:0] na);
    reset_n <= 1'b0;
    nvm_addr_valid <= nv;
    nvm_addr <= na;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask

  // Main sequence
  initial begin
    reset_n = 1'b0;
    nvm_addr_valid = 1'b0;
    nvm_addr = 7'h00;
    phase_start = 1'b0;
    wr_ready = 1'b0;
    rd_ack = 1'b0;
    rd_data = 8'h00;
    phase_seen = 1'b0;
    own = DEFAULT_SLAVE_ADDR;
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'($random(seed));
    end
    do_reset(1'b0, 7'h00);
    bus_write(own, 8'hfe, 3, 3, 1'b1);
    bus_write(own, 8'h07, 4, 4, 1'b1);
    chk("held until phase", 16'h0, 16'(wr_valid));
    apply_phase();
    bus_write(7'h2c, 8'h10, 2, 0, 1'b0);
    bus_read(8'h30, 3);
    bus_read(8'hfe, 3);
    // Full buffer: the byte after the last free slot is refused
    bus_write(own, 8'h40, FIFO_DEPTH + 2, FIFO_DEPTH, 1'b1);
    apply_phase();
    do_reset(1'b1, 7'h51);
    bus_write(own, 8'h20, 1, 0, 1'b0);
    own = 7'h51;
    bus_write(own, 8'h20, 2, 2, 1'b1);
    bus_read(8'h11, 2);
    apply_phase();
    conclude();
  end

  // Watchdog against a hung bus
  initial begin
    #400000;
    n_errors++;
    conclude();
  end
endmodule
